// file: core/mil_pkg.sv
// Package: constants and carrier types of the interrupt logic
package mil_pkg;

	// ==========================================
	// Register indices (byte address = 4 * index)
	localparam logic [9:0] OPTION_IDX = 10'h081;
	localparam logic [9:0] IRQ_CONTROL_REG_IDX = 10'h00B;
	localparam logic [9:0] STAT_IDX = 10'h010;
	localparam int ADDR_W = 12;

	// ==========================================
	// Reset values and masks
	localparam logic [7:0] OPTION_RST = 8'hFF;
	localparam logic [7:0] IRQ_CONTROL_REG_RST = 8'h00;
	localparam logic [7:0] IRQ_CONTROL_REG_MASK = 8'hBF;

	// ==========================================
	// Field positions
	localparam int GIE_BIT = 7;
	localparam int TIMER_OVERFLOW_ENABLE_BIT = 5;
	localparam int EXT_IRQ_ENABLE_BIT = 4;
	localparam int PORT_CHANGE_ENABLE_BIT = 3;
	localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
	localparam int EXT_IRQ_FLAG_BIT = 1;
	localparam int PORT_CHANGE_FLAG_BIT = 0;
	localparam int EDGE_BIT = 6;
	localparam int ST_REQ_BIT = 0;
	localparam int ST_SLEEP_BIT = 1;
	localparam int ST_ENTRY_BIT = 2;

	// ==========================================
	// Core and bus constants
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam int CYC_CLKS = 4;
	localparam int NUM_SRC = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================
	// Types
	typedef enum logic [1:0] {
		ENT_IDLE = 2'b01,
		ENT_DUMMY = 2'b10
	} mil_entry_t;

	typedef struct packed {
		logic sleep_exec;
		logic return_from_irq;
		logic port_read;
		logic timer_overflow;
	} mil_core_cmd_t;

	typedef struct packed {
		logic irq_request;
		logic force_nop;
		logic stack_push;
		logic pc_load;
		logic [12:0] pc_vector;
		logic wake;
		logic sleeping;
	} mil_core_rsp_t;

endpackage

// file: core/mil_pin_sync.sv
// Two-stage synchroniser plus one history stage for pin inputs
`timescale 1ns/1ns
module mil_pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins
	input wire logic [WIDTH-1:0] pin_async,
	// Synchronised value and its previous sample
	output logic [WIDTH-1:0] pin_sync,
	output logic [WIDTH-1:0] pin_prev
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] prev_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= pin_async;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign pin_sync = sync_ff;
	assign pin_prev = prev_ff;

endmodule

// file: core/mil_irq_logic.sv
// Interrupt logic: flags, enables, core entry, sleep wake-up, AXI4-Lite registers
//
// Functional notes
// - Three sources: pin edge, timer, port change
// - Global enable passes or blocks all requests
// - Reset clears the global enable
// - Return-from-interrupt sets global enable again
// - Entry clears enable, pushes, loads vector 0004h
// - Pin event to vector in few cycles
// - Flags set regardless of any enable
// - Enable clear forces NOP, defers requests
// - Pin edge polarity chosen by option bit 6
// - Selected pin edge sets external flag
// - External enable clear blocks pin interrupt
// - Enabled pin event wakes core from sleep
// - Timer enable bit gates timer interrupt
// - Change on port pins 7:4 sets flag
// - Port change has its own enable bit
// - Read/change race may set port flag
// - Only return address saved on entry
// - Wake ignores global enable; continue in line
// - Enabled wake runs prefetched, then vectors
// - Pending source at sleep wakes at once
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
module mil_irq_logic #(
	parameter int CYC_CLKS = mil_pkg::CYC_CLKS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [mil_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [mil_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins
	input wire logic ext_irq_pin,
	input wire logic [3:0] upper_port,
	// Core side
	input wire mil_pkg::mil_core_cmd_t core_cmd,
	output mil_pkg::mil_core_rsp_t core_rsp,
	output logic clock_phase_two,
	output logic [7:0] timer_option
);

	// ==========================================
	// Instruction cycle divider
	localparam int PH_W = $clog2(CYC_CLKS);
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(CYC_CLKS - 1);
	localparam logic [PH_W-1:0] PH_TWO = PH_W'(1);
	logic [PH_W-1:0] phase_ff;
	logic cyc_en;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_ff <= '0;
		end else if (cyc_en) begin
			phase_ff <= '0;
		end else begin
			phase_ff <= phase_ff + PH_W'(1);
		end
	end

	assign cyc_en = (phase_ff == PH_LAST);
	assign clock_phase_two = (phase_ff == PH_TWO);

	// ==========================================
	// Pin synchronisers
	logic int_sync;
	logic int_prev;
	logic [3:0] port_sync;

	mil_pin_sync #(.WIDTH(1)) u_int_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_async(ext_irq_pin),
		.pin_sync(int_sync),
		.pin_prev(int_prev)
	);

	mil_pin_sync #(.WIDTH(4)) u_port_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_async(upper_port),
		.pin_sync(port_sync),
		.pin_prev()
	);

	// ==========================================
	// Registers and event detection
	logic [7:0] option_ff;
	logic [7:0] irq_control_reg_ff;
	logic [3:0] port_latch_ff;
	logic ext_edge;
	logic port_change;
	logic [mil_pkg::NUM_SRC-1:0] src_set;
	logic [mil_pkg::NUM_SRC-1:0] src_flag;
	logic [mil_pkg::NUM_SRC-1:0] src_en;
	logic pending;
	logic irq_req;

	// Rising when edge select set, falling when clear
	assign ext_edge = option_ff[mil_pkg::EDGE_BIT] ? (int_sync && !int_prev) : (!int_sync && int_prev);
	// Compare against value latched at the last port read; a change racing the read only sets the flag
	assign port_change = (port_sync != port_latch_ff);
	assign src_set = {core_cmd.timer_overflow, ext_edge, port_change};
	assign src_flag = {irq_control_reg_ff[mil_pkg::TIMER_OVERFLOW_FLAG_BIT], irq_control_reg_ff[mil_pkg::EXT_IRQ_FLAG_BIT], irq_control_reg_ff[mil_pkg::PORT_CHANGE_FLAG_BIT]};
	assign src_en = {irq_control_reg_ff[mil_pkg::TIMER_OVERFLOW_ENABLE_BIT], irq_control_reg_ff[mil_pkg::EXT_IRQ_ENABLE_BIT], irq_control_reg_ff[mil_pkg::PORT_CHANGE_ENABLE_BIT]};
	assign pending = |(src_flag & src_en);
	assign irq_req = pending && irq_control_reg_ff[mil_pkg::GIE_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_latch_ff <= '0;
		end else if (core_cmd.port_read) begin
			port_latch_ff <= port_sync;
		end
	end

	// ==========================================
	// AXI4-Lite write path
	logic aw_have_ff;
	logic w_have_ff;
	logic [mil_pkg::ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic wstrb0_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic wr_do;
	logic wr_hit_opt;
	logic wr_hit_ic;
	logic wr_hit_st;
	logic wr_ic;

	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready = !w_have_ff && !bvalid_ff;
	assign wr_do = aw_have_ff && w_have_ff && !bvalid_ff;
	assign wr_hit_opt = (awaddr_ff == {mil_pkg::OPTION_IDX, 2'h0});
	assign wr_hit_ic = (awaddr_ff == {mil_pkg::IRQ_CONTROL_REG_IDX, 2'h0});
	assign wr_hit_st = (awaddr_ff == {mil_pkg::STAT_IDX, 2'h0});
	assign wr_ic = wr_do && wr_hit_ic && wstrb0_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			awaddr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_have_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_ff <= 1'b0;
			wdata_ff <= '0;
			wstrb0_ff <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb0_ff <= s_axi_wstrb[0];
		end else if (wr_do) begin
			w_have_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= mil_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wr_hit_opt || wr_hit_ic || wr_hit_st) ? mil_pkg::RESP_OKAY : mil_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			option_ff <= mil_pkg::OPTION_RST;
		end else if (wr_do && wr_hit_opt && wstrb0_ff) begin
			option_ff <= wdata_ff[7:0];
		end
	end

	assign timer_option = option_ff;

	// ==========================================
	// Entry sequence and sleep
	mil_pkg::mil_entry_t state_ff;
	logic push_ff;
	logic load_ff;
	logic block_ff;
	logic sleeping_ff;
	logic wake_ff;
	logic accept;

	// Taken at an instruction boundary unless the core sleeps or a NOP slot is pending
	assign accept = cyc_en && irq_req && !sleeping_ff && !block_ff && !(wr_ic && !wdata_ff[mil_pkg::GIE_BIT])
		&& (state_ff == mil_pkg::ENT_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= mil_pkg::ENT_IDLE;
			push_ff <= 1'b0;
			load_ff <= 1'b0;
		end else begin
			push_ff <= 1'b0;
			load_ff <= 1'b0;
			case (state_ff)
				mil_pkg::ENT_IDLE: begin
					if (accept) begin
						state_ff <= mil_pkg::ENT_DUMMY;
						push_ff <= 1'b1;
					end
				end
				mil_pkg::ENT_DUMMY: begin
					if (cyc_en) begin
						state_ff <= mil_pkg::ENT_IDLE;
						load_ff <= 1'b1;
					end
				end
				default: begin
					state_ff <= mil_pkg::ENT_IDLE;
				end
			endcase
		end
	end

	// One NOP slot after software clears the global enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			block_ff <= 1'b0;
		end else if (wr_ic && !wdata_ff[mil_pkg::GIE_BIT]) begin
			block_ff <= 1'b1;
		end else if (cyc_en) begin
			block_ff <= 1'b0;
		end
	end

	// Wake on any enabled flag, whatever the global enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleeping_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= sleeping_ff && pending;
			if (sleeping_ff && pending) begin
				sleeping_ff <= 1'b0;
			end else if (core_cmd.sleep_exec) begin
				sleeping_ff <= 1'b1;
			end
		end
	end

	// ==========================================
	// Interrupt control register
	logic [7:0] ic_base;
	logic [mil_pkg::NUM_SRC-1:0] flag_base;

	always_comb begin
		ic_base = wr_ic ? (wdata_ff[7:0] & mil_pkg::IRQ_CONTROL_REG_MASK) : irq_control_reg_ff;
		flag_base = {ic_base[mil_pkg::TIMER_OVERFLOW_FLAG_BIT], ic_base[mil_pkg::EXT_IRQ_FLAG_BIT], ic_base[mil_pkg::PORT_CHANGE_FLAG_BIT]};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_control_reg_ff <= mil_pkg::IRQ_CONTROL_REG_RST;
		end else begin
			irq_control_reg_ff <= ic_base;
			// Hardware set wins over a clearing write
			irq_control_reg_ff[mil_pkg::TIMER_OVERFLOW_FLAG_BIT] <= flag_base[2] | src_set[2];
			irq_control_reg_ff[mil_pkg::EXT_IRQ_FLAG_BIT] <= flag_base[1] | src_set[1];
			irq_control_reg_ff[mil_pkg::PORT_CHANGE_FLAG_BIT] <= flag_base[0] | src_set[0];
			if (accept) begin
				irq_control_reg_ff[mil_pkg::GIE_BIT] <= 1'b0;
			end else if (core_cmd.return_from_irq) begin
				irq_control_reg_ff[mil_pkg::GIE_BIT] <= 1'b1;
			end
		end
	end

	// ==========================================
	// AXI4-Lite read path
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic [7:0] stat_val;

	assign s_axi_arready = !rvalid_ff;

	always_comb begin
		stat_val = '0;
		stat_val[mil_pkg::ST_REQ_BIT] = irq_req;
		stat_val[mil_pkg::ST_SLEEP_BIT] = sleeping_ff;
		stat_val[mil_pkg::ST_ENTRY_BIT] = (state_ff == mil_pkg::ENT_DUMMY);
		rd_mux = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			{mil_pkg::OPTION_IDX, 2'h0}: rd_mux[7:0] = option_ff;
			{mil_pkg::IRQ_CONTROL_REG_IDX, 2'h0}: rd_mux[7:0] = irq_control_reg_ff;
			{mil_pkg::STAT_IDX, 2'h0}: rd_mux[7:0] = stat_val;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= mil_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_hit ? mil_pkg::RESP_OKAY : mil_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ==========================================
	// Core response
	always_comb begin
		core_rsp.irq_request = irq_req;
		core_rsp.force_nop = (state_ff == mil_pkg::ENT_DUMMY) || block_ff;
		core_rsp.stack_push = push_ff;
		core_rsp.pc_load = load_ff;
		core_rsp.pc_vector = mil_pkg::IRQ_VECTOR;
		core_rsp.wake = wake_ff;
		core_rsp.sleeping = sleeping_ff;
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_gie_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !irq_control_reg_ff[mil_pkg::GIE_BIT])
		else $error("global enable not cleared by reset");
	a_req_gated_gie: assert property (core_rsp.irq_request |-> irq_control_reg_ff[mil_pkg::GIE_BIT] &&
		((irq_control_reg_ff[mil_pkg::TIMER_OVERFLOW_FLAG_BIT] && irq_control_reg_ff[mil_pkg::TIMER_OVERFLOW_ENABLE_BIT]) ||
		(irq_control_reg_ff[mil_pkg::EXT_IRQ_FLAG_BIT] && irq_control_reg_ff[mil_pkg::EXT_IRQ_ENABLE_BIT]) ||
		(irq_control_reg_ff[mil_pkg::PORT_CHANGE_FLAG_BIT] && irq_control_reg_ff[mil_pkg::PORT_CHANGE_ENABLE_BIT])))
		else $error("request without global enable");
	a_entry_clears_gie: assert property (push_ff |-> !irq_control_reg_ff[mil_pkg::GIE_BIT])
		else $error("global enable still set after entry");
	a_vector_follows_push: assert property (push_ff |-> ##[1:8] (load_ff && core_rsp.pc_vector == 13'h0004))
		else $error("vector not loaded after push");
	a_return_from_irq_sets_gie: assert property (core_cmd.return_from_irq && !accept |=> irq_control_reg_ff[mil_pkg::GIE_BIT])
		else $error("return did not set global enable");
	a_edge_sets_flag: assert property (ext_edge |=> irq_control_reg_ff[mil_pkg::EXT_IRQ_FLAG_BIT])
		else $error("pin edge lost");
	a_timer_sets_flag: assert property (core_cmd.timer_overflow |=> irq_control_reg_ff[mil_pkg::TIMER_OVERFLOW_FLAG_BIT])
		else $error("timer overflow lost");
	a_port_sets_flag: assert property (port_change |=> irq_control_reg_ff[mil_pkg::PORT_CHANGE_FLAG_BIT])
		else $error("port change lost");
	a_nop_after_clear: assert property (wr_ic && !wdata_ff[mil_pkg::GIE_BIT] |=> core_rsp.force_nop && !push_ff)
		else $error("no NOP slot after enable clear");
	a_wake_on_pending: assert property (sleeping_ff && pending |=> wake_ff && !sleeping_ff)
		else $error("no wake with enabled flag");
	a_no_entry_asleep: assert property (sleeping_ff |-> !accept)
		else $error("entry while sleeping");

	c_entry: cover property (push_ff ##[1:8] load_ff);
	c_wake_gie_clear: cover property (wake_ff && !irq_control_reg_ff[mil_pkg::GIE_BIT]);
	c_wake_then_entry: cover property (wake_ff ##[1:16] push_ff);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == mil_pkg::RESP_SLVERR);

endmodule

// file: dv/mil_core_model.sv
// Processor core model that answers the interrupt logic
`timescale 1ns/1ns
module mil_core_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Interrupt logic side
	input wire mil_pkg::mil_core_rsp_t core_rsp,
	output mil_pkg::mil_core_cmd_t core_cmd,
	// Counts seen
	output int pushes,
	output int wakes,
	output int errs
);
	logic [12:0] ret_stack[$];
	logic [12:0] pc_ff;
	int gap;
	initial core_cmd = '0;
	// ==========================================
	// Program counter and return stack
	always @(posedge aclk) begin
		if (!aresetn) begin
			pushes <= 0;
			wakes <= 0;
			errs <= 0;
			gap <= 0;
			pc_ff <= 13'h0000;
		end else begin
			pc_ff <= pc_ff + 13'h0001;
			gap <= gap + 1;
			if (core_rsp.wake) begin
				wakes <= wakes + 1;
			end
			if (core_rsp.stack_push) begin
				pushes <= pushes + 1;
				gap <= 1;
				ret_stack.push_back(pc_ff);
			end
			if (core_rsp.pc_load) begin
				if (gap != 4 || core_rsp.pc_vector !== mil_pkg::IRQ_VECTOR) begin
					errs <= errs + 1;
				end
				pc_ff <= core_rsp.pc_vector;
			end
			if (core_cmd.return_from_irq && ret_stack.size() > 0) begin
				pc_ff <= ret_stack.pop_back();
			end
		end
	end
	// ==========================================
	// One-cycle command pulse
	task automatic pulse(input logic [3:0] c);
		@(posedge aclk);
		core_cmd <= mil_pkg::mil_core_cmd_t'(c);
		@(posedge aclk);
		core_cmd <= '0;
	endtask
endmodule

// file: dv/test_mcu_interrupt_logic.sv
// Testbench of the interrupt logic
`timescale 1ns/1ns
module test_mcu_interrupt_logic;
	localparam logic [11:0] A_OPT = {mil_pkg::OPTION_IDX, 2'b00};
	localparam logic [11:0] A_IC = {mil_pkg::IRQ_CONTROL_REG_IDX, 2'b00};
	localparam logic [11:0] A_ST = {mil_pkg::STAT_IDX, 2'b00};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic aw_v = 1'b0;
	logic w_v = 1'b0;
	logic b_r = 1'b0;
	logic ar_v = 1'b0;
	logic r_r = 1'b0;
	logic pin = 1'b0;
	logic [11:0] aw_a = 12'h000;
	logic [11:0] ar_a = 12'h000;
	logic [31:0] w_d = 32'h0;
	logic [3:0] port = 4'h0;
	logic [3:0] w_s = 4'hF;
	logic ph2;
	logic [7:0] topt;
	int ph_n = 0;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [1:0] b_resp, r_resp, resp;
	logic [31:0] r_d;
	logic [7:0] rd;
	mil_pkg::mil_core_cmd_t cmd;
	mil_pkg::mil_core_rsp_t rsp;
	int pushes, wakes, errs;
	int fails = 0;
	int comparisons = 0;
	always #10 aclk = ~aclk;
	mil_irq_logic i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
		.s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
		.s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
		.ext_irq_pin(pin), .upper_port(port), .core_cmd(cmd), .core_rsp(rsp),
		.clock_phase_two(ph2), .timer_option(topt));
	mil_core_model i_core (.aclk(aclk), .aresetn(aresetn), .core_rsp(rsp), .core_cmd(cmd),
		.pushes(pushes), .wakes(wakes), .errs(errs));
	// ==========================================
	// Checks and register bus tasks
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		aw_a <= a;
		w_d <= {24'h0, d};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		forever begin
			@(negedge aclk);
			ta = aw_v && aw_rdy;
			tw = w_v && w_rdy;
			tb = b_v && b_r;
			resp = b_resp;
			@(posedge aclk);
			if (ta) aw_v <= 1'b0;
			if (tw) w_v <= 1'b0;
			if (tb) begin
				b_r <= 1'b0;
				break;
			end
		end
	endtask
	task rd_reg(input logic [11:0] a);
		logic ta, tr;
		@(posedge aclk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		forever begin
			@(negedge aclk);
			ta = ar_v && ar_rdy;
			tr = r_v && r_r;
			rd = r_d[7:0];
			resp = r_resp;
			@(posedge aclk);
			if (ta) ar_v <= 1'b0;
			if (tr) begin
				r_r <= 1'b0;
				break;
			end
		end
	endtask
	task wait_push(input int n);
		for (int i = 0; i < 40 && pushes < n; i++) @(posedge aclk);
		repeat (6) @(posedge aclk);
	endtask
	task tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ==========================================
	// Watchdog
	initial begin
		#400000;
		fails++;
		$display("[FAIL] watchdog expected done seen hang");
		tally_and_finish;
	end
	// ==========================================
	// Tests
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(A_OPT);
		chk("option reset", 8'hFF, rd);
		rd_reg(A_IC);
		chk("control reset", 8'h00, rd);
		rd_reg(12'hFFC);
		chk("unmapped resp", 8'h02, {6'h0, resp});
		for (int i = 0; i < 8; i++) begin
			@(negedge aclk);
			ph_n += ph2;
		end
		chk("phase two", 8'h02, 8'(ph_n));
		$display("test reset done");
		pin <= 1'b1;
		repeat (8) @(posedge aclk);
		rd_reg(A_IC);
		chk("rising flag", 8'h02, rd);
		wr(A_IC, 8'h00);
		wr(A_OPT, 8'hBF);
		chk("timer option", 8'hBF, topt);
		pin <= 1'b0;
		repeat (8) @(posedge aclk);
		rd_reg(A_IC);
		chk("falling flag", 8'h02, rd);
		wr(A_IC, 8'h00);
		pin <= 1'b1;
		repeat (8) @(posedge aclk);
		rd_reg(A_IC);
		chk("unselected edge", 8'h00, rd);
		wr(A_OPT, 8'hFF);
		w_s <= 4'h0;
		wr(A_OPT, 8'h00);
		w_s <= 4'hF;
		chk("strobe off", 8'hFF, topt);
		$display("test pin edge done");
		i_core.pulse(4'h1);
		repeat (3) @(posedge aclk);
		rd_reg(A_IC);
		chk("timer flag", 8'h04, rd);
		wr(A_IC, 8'h00);
		i_core.pulse(4'h2);
		port <= 4'h8;
		repeat (8) @(posedge aclk);
		rd_reg(A_IC);
		chk("port flag", 8'h01, rd);
		i_core.pulse(4'h2);
		wr(A_IC, 8'h00);
		$display("test sources done");
		wr(A_IC, 8'hA4);
		wait_push(1);
		chk("entry push", 8'h01, 8'(pushes));
		chk("entry timing", 8'h00, 8'(errs));
		rd_reg(A_IC);
		chk("entry gie", 8'h24, rd);
		wr(A_IC, 8'h20);
		i_core.pulse(4'h4);
		rd_reg(A_IC);
		chk("return gie", 8'hA0, rd);
		wr(A_IC, 8'h82);
		wait_push(2);
		chk("masked pin", 8'h01, 8'(pushes));
		rd_reg(A_ST);
		chk("no request", 8'h00, rd);
		wr(A_IC, 8'h92);
		wait_push(2);
		chk("enabled pin", 8'h02, 8'(pushes));
		$display("test entry done");
		wr(A_IC, 8'h10);
		i_core.pulse(4'h8);
		rd_reg(A_ST);
		chk("sleeping", 8'h02, rd);
		pin <= 1'b0;
		repeat (4) @(posedge aclk);
		pin <= 1'b1;
		repeat (10) @(posedge aclk);
		chk("wake count", 8'h01, 8'(wakes));
		rd_reg(A_ST);
		chk("awake", 8'h00, rd);
		chk("no entry", 8'h02, 8'(pushes));
		i_core.pulse(4'h8);
		repeat (4) @(posedge aclk);
		chk("pending wake", 8'h02, 8'(wakes));
		$display("test sleep done");
		tally_and_finish;
	end
endmodule
